// ===== gpt_pkg.sv
// constants shared by the general-purpose timer pair
package gpt_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_MRA  = 8'h04;
  localparam logic [7:0] OFS_MRB  = 8'h08;
  localparam logic [7:0] OFS_CTL  = 8'h0C;
  localparam logic [7:0] OFS_IMR  = 8'h18;
  localparam logic [7:0] OFS_RIS  = 8'h1C;
  localparam logic [7:0] OFS_MIS  = 8'h20;
  localparam logic [7:0] OFS_ICR  = 8'h24;
  localparam logic [7:0] OFS_ILRA = 8'h28;
  localparam logic [7:0] OFS_ILRB = 8'h2C;
  localparam logic [7:0] OFS_MATA = 8'h30;
  localparam logic [7:0] OFS_MATB = 8'h34;
  localparam logic [7:0] OFS_PRA  = 8'h38;
  localparam logic [7:0] OFS_PRB  = 8'h3C;
  localparam logic [7:0] OFS_CNTA = 8'h48;
  localparam logic [7:0] OFS_CNTB = 8'h4C;

  // ****************************************
  // configuration and mode encodings
  // ****************************************
  localparam logic [2:0] CFG_32   = 3'h0;
  localparam logic [2:0] CFG_RTC  = 3'h1;
  localparam logic [2:0] CFG_16   = 3'h4;
  localparam logic [1:0] MODE_ONE = 2'h1;
  localparam logic [1:0] MODE_PER = 2'h2;
  localparam logic [1:0] MODE_CAP = 2'h3;
  localparam int         MR_CMR   = 2;

  // ****************************************
  // control byte fields, one byte per half
  // ****************************************
  localparam int CTL_EN    = 0;
  localparam int CTL_STALL = 1;
  localparam int CTL_EV    = 2;
  localparam int CTL_RTCOV = 4;
  localparam int CTL_TRIG  = 5;
  localparam logic [1:0] EV_RISE = 2'h0;
  localparam logic [1:0] EV_FALL = 2'h1;
  localparam logic [1:0] EV_BOTH = 2'h3;

  // ****************************************
  // status bits, half B sits 8 bits higher
  // ****************************************
  localparam int ST_TO   = 0;
  localparam int ST_CM   = 1;
  localparam int ST_RTC  = 3;
  localparam int ST_HALF = 8;

  // ****************************************
  // reset values and timing
  // ****************************************
  localparam logic [15:0] CNT_RST   = 16'hFFFF;
  localparam logic [15:0] MATCH_RST = 16'hFFFF;
  localparam logic [7:0]  PRE_RST   = 8'h00;
  localparam logic [31:0] RTC_START = 32'h0000_0001;
  localparam int RTC_PIN_HZ = 32768;
  localparam int RTC_OUT_HZ = 1;
  localparam int RTC_DIV_N  = RTC_PIN_HZ / RTC_OUT_HZ;

endpackage

// ===== gpt_pair.sv
// general-purpose timer pair with a classic wishbone register slave
//
// Behaviour
// R01: after reset both counters and both load registers hold FFFF, block idle.
// R02: after reset both prescale registers hold zero.
// R03: configuration 0 selects 32-bit one-shot/periodic, 1 selects 32-bit real-time.
// R04: configuration 4 splits into two independent 16-bit timers.
// R05: 32-bit load write stores low half in A, high half in B.
// R06: 32-bit count read returns B count high, A count low.
// R07: 32-bit down-count; zero reloads next cycle; one-shot stops and clears enable.
// R08: reaching zero sets sticky raw timeout flag; masked flag when unmasked.
// R09: trigger enable gives a one-cycle pulse when the counter hits zero.
// R10: load write while counting is taken by the counter next cycle.
// R11: stall bit holds the count until it is released; edge-count mode ignores the stall bit.
// R12: real-time counts up, starts at 1; later loads only via match.
// R13: real-time divides the 32768 Hz even pin clock to 1 Hz.
// R14: real-time rolls over to zero at match and keeps counting.
// R15: real-time match sets raw, masked flags and interrupt; clear bit clears.
// R16: real-time stall override makes both stall bits ineffective.
// R17: 16-bit halves count down with 8-bit prescaler, own one-shot/periodic mode.
// R18: 16-bit zero reloads interval and prescale; one-shot clears half enable.
// R19: prescale 0 gives one clock per count, FF gives 256.
// R20: capture bit 0 selects edge counting on rising, falling or both.
// R21: software sets load minus match equal to the edges to count.
// R22: each edge decrements; on match flag, reload, disable, ignore edges.
// R23: pin edges are synchronised before detection, each counted once.
`timescale 1ns/10ps

module gpt_pair
  import gpt_pkg::*;
#(
  parameter int RTC_DIV = RTC_DIV_N
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // capture/compare pins, bit 0 even, bit 1 odd
  input  wire logic [1:0]  ccp_i,
  // converter triggers and interrupt
  output logic      [1:0]  trig_o,
  output logic             irq_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0]       cfg;
    logic [1:0][2:0]  mr;
    logic [1:0][7:0]  ctl;
    logic [1:0][15:0] ilr;
    logic [1:0][15:0] cnt;
    logic [1:0][15:0] mtc;
    logic [15:0]      mtc_hi;
    logic [1:0][7:0]  pr;
    logic [1:0][7:0]  pcnt;
    logic [15:0]      imr;
    logic [15:0]      ris;
    logic [15:0]      div;
    logic [1:0][2:0]  sy;
    logic             ack;
    logic [31:0]      dat;
    logic [1:0]       trig;
    logic             irq;
  } st_t;

  st_t         st_r;
  st_t         st_nxt;
  logic        req;
  logic        wide;
  logic        rtc;
  logic        run;
  logic        tick;
  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [15:0] set;
  logic [31:0] c32;
  logic [31:0] rd;
  logic [31:0] wd;
  logic [15:0] dec;
  logic [15:0] mis;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [31:0] m;
    m = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        m[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic edge_hit(input logic [1:0] ev,
                                    input logic       r,
                                    input logic       f);
    logic hit;
    hit = 1'b0;
    if (ev == EV_RISE) begin
      hit = r;
    end else if (ev == EV_FALL) begin
      hit = f;
    end else if (ev == EV_BOTH) begin
      hit = r | f;
    end
    return hit;
  endfunction

  // status bit of one half, half B sits a byte above half A
  function automatic int st_bit(input int h,
                                input int b);
    return h * ST_HALF + b;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.trig = 2'b00;
    set = 16'h0000;
    tick = 1'b0;
    dec = 16'h0000;
    mis = st_r.ris & st_r.imr;
    req = cyc_i & stb_i & ~st_r.ack;
    wide = (st_r.cfg == CFG_32) | (st_r.cfg == CFG_RTC);
    rtc = st_r.cfg == CFG_RTC;
    c32 = {st_r.cnt[1], st_r.cnt[0]};
    // real-time ignores stall bits when overridden
    run = ~(st_r.ctl[0][CTL_STALL] | st_r.ctl[1][CTL_STALL])
          | st_r.ctl[0][CTL_RTCOV]; // R16

    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    // only the last two stages feed edge detection
    for (int h = 0; h < 2; h++) begin
      st_nxt.sy[h] = {st_r.sy[h][1:0], ccp_i[h]}; // R23
      rise[h] = st_r.sy[h][1] & ~st_r.sy[h][2];
      fall[h] = ~st_r.sy[h][1] & st_r.sy[h][2];
    end

    // ****************************************
    // counting
    // ****************************************
    // combined 32-bit modes
    if (wide) begin
      if (rtc) begin
        if (st_r.ctl[0][CTL_EN] && run && rise[0]) begin
          if (st_r.div == 16'(RTC_DIV - 1)) begin
            st_nxt.div = 16'h0000; // R13
            tick = 1'b1;
          end else begin
            st_nxt.div = st_r.div + 16'h0001;
          end
        end
        // a stopped clock restarts on a whole second
        if (!st_r.ctl[0][CTL_EN]) begin
          st_nxt.div = 16'h0000;
        end
        if (tick) begin
          if (c32 == {st_r.mtc_hi, st_r.mtc[0]}) begin
            c32 = 32'h0000_0000; // R14
            set[ST_RTC] = 1'b1; // R15
          end else begin
            c32 = c32 + 32'h0000_0001; // R12
          end
        end
      end else if (st_r.ctl[0][CTL_EN] && !st_r.ctl[0][CTL_STALL]) begin // R11
        if (c32 == 32'h0000_0000) begin
          c32 = {st_r.ilr[1], st_r.ilr[0]}; // R07
          if (st_r.mr[0][1:0] == MODE_ONE) begin
            st_nxt.ctl[0][CTL_EN] = 1'b0; // R07
          end
        end else begin
          c32 = c32 - 32'h0000_0001; // R07
          if (c32 == 32'h0000_0000) begin
            set[ST_TO] = 1'b1; // R08
            st_nxt.trig[0] = st_r.ctl[0][CTL_TRIG]; // R09
          end
        end
      end
      st_nxt.cnt[1] = c32[31:16];
      st_nxt.cnt[0] = c32[15:0];
    end else begin
      // each half runs on its own in the 16-bit modes
      for (int h = 0; h < 2; h++) begin
        if (st_r.mr[h][1:0] == MODE_CAP) begin
          if (!st_r.mr[h][MR_CMR] && st_r.ctl[h][CTL_EN]
              && edge_hit(st_r.ctl[h][CTL_EV +: 2], rise[h], fall[h])) begin // R20
            // the stepped value is compared, so the matching edge is the last one counted
            dec = st_r.cnt[h] - 16'h0001; // R22
            if (dec == st_r.mtc[h]) begin
              set[st_bit(h, ST_CM)] = 1'b1; // R22
              st_nxt.cnt[h] = st_r.ilr[h];
              st_nxt.ctl[h][CTL_EN] = 1'b0; // R22
            end else begin
              st_nxt.cnt[h] = dec;
            end
          end
        end else if (st_r.ctl[h][CTL_EN] && !st_r.ctl[h][CTL_STALL]) begin // R11
          if (st_r.cnt[h] == 16'h0000) begin
            st_nxt.cnt[h] = st_r.ilr[h]; // R18
            st_nxt.pcnt[h] = st_r.pr[h]; // R18
            if (st_r.mr[h][1:0] == MODE_ONE) begin
              st_nxt.ctl[h][CTL_EN] = 1'b0; // R18
            end
          end else if (st_r.pcnt[h] == 8'h00) begin
            // prescale value p gives p+1 clocks per count
            st_nxt.pcnt[h] = st_r.pr[h]; // R19
            st_nxt.cnt[h] = st_r.cnt[h] - 16'h0001; // R17
            if (st_r.cnt[h] == 16'h0001) begin
              set[st_bit(h, ST_TO)] = 1'b1; // R08
              st_nxt.trig[h] = st_r.ctl[h][CTL_TRIG]; // R09
            end
          end else begin
            st_nxt.pcnt[h] = st_r.pcnt[h] - 8'h01;
          end
        end
      end
    end

    // ****************************************
    // register read decode
    // ****************************************
    rd = 32'h0000_0000;
    if (adr_i == OFS_CFG) begin
      rd = {29'h0, st_r.cfg};
    end else if (adr_i == OFS_MRA) begin
      rd = {29'h0, st_r.mr[0]};
    end else if (adr_i == OFS_MRB) begin
      rd = {29'h0, st_r.mr[1]};
    end else if (adr_i == OFS_CTL) begin
      rd = {16'h0, st_r.ctl[1], st_r.ctl[0]};
    end else if (adr_i == OFS_IMR) begin
      rd = {16'h0, st_r.imr};
    end else if (adr_i == OFS_RIS) begin
      rd = {16'h0, st_r.ris};
    end else if (adr_i == OFS_MIS) begin
      rd = {16'h0, mis};
    end else if (adr_i == OFS_ILRA) begin
      rd = wide ? {st_r.ilr[1], st_r.ilr[0]} : {16'h0, st_r.ilr[0]};
    end else if (adr_i == OFS_ILRB) begin
      rd = {16'h0, st_r.ilr[1]};
    end else if (adr_i == OFS_MATA) begin
      rd = {st_r.mtc_hi, st_r.mtc[0]};
    end else if (adr_i == OFS_MATB) begin
      rd = {16'h0, st_r.mtc[1]};
    end else if (adr_i == OFS_PRA) begin
      rd = {24'h0, st_r.pr[0]};
    end else if (adr_i == OFS_PRB) begin
      rd = {24'h0, st_r.pr[1]};
    end else if (adr_i == OFS_CNTA) begin
      rd = wide ? {st_r.cnt[1], st_r.cnt[0]} : {16'h0, st_r.cnt[0]}; // R06
    end else if (adr_i == OFS_CNTB) begin
      rd = {16'h0, st_r.cnt[1]};
    end
    wd = merge(rd, dat_i, sel_i);

    // ****************************************
    // register writes, after counting so that a
    // load written now wins over the count step
    // ****************************************
    if (req) begin
      st_nxt.ack = 1'b1;
      st_nxt.dat = rd;
      if (we_i) begin
        if (adr_i == OFS_CFG) begin
          st_nxt.cfg = wd[2:0]; // R03 R04
          if (wd[2:0] == CFG_RTC && st_r.cfg != CFG_RTC) begin
            st_nxt.cnt[1] = RTC_START[31:16]; // R12
            st_nxt.cnt[0] = RTC_START[15:0];
            st_nxt.div = 16'h0000;
          end
        end else if (adr_i == OFS_MRA) begin
          st_nxt.mr[0] = wd[2:0];
        end else if (adr_i == OFS_MRB) begin
          st_nxt.mr[1] = wd[2:0];
        end else if (adr_i == OFS_CTL) begin
          st_nxt.ctl[0] = wd[7:0];
          st_nxt.ctl[1] = wd[15:8];
          // a fresh start runs a whole prescale period before the first step
          for (int h = 0; h < 2; h++) begin
            if (wd[h * 8 + CTL_EN] && !st_r.ctl[h][CTL_EN]) begin
              st_nxt.pcnt[h] = st_r.pr[h]; // R19
            end
          end
        end else if (adr_i == OFS_IMR) begin
          st_nxt.imr = wd[15:0];
        end else if (adr_i == OFS_ICR) begin
          st_nxt.ris = st_r.ris & ~wd[15:0]; // R08 R15
        end else if (adr_i == OFS_ILRA) begin
          st_nxt.ilr[0] = wd[15:0];
          if (wide) begin
            st_nxt.ilr[1] = wd[31:16]; // R05
          end
          // real-time loads only through the match path
          if (!rtc) begin
            st_nxt.cnt[0] = wd[15:0]; // R10
            if (wide) begin
              st_nxt.cnt[1] = wd[31:16]; // R10
            end
          end
        end else if (adr_i == OFS_ILRB) begin
          st_nxt.ilr[1] = wd[15:0];
          if (!wide) begin
            st_nxt.cnt[1] = wd[15:0]; // R10
          end
        end else if (adr_i == OFS_MATA) begin
          st_nxt.mtc[0] = wd[15:0];
          st_nxt.mtc_hi = wd[31:16]; // R12
        end else if (adr_i == OFS_MATB) begin
          st_nxt.mtc[1] = wd[15:0];
        end else if (adr_i == OFS_PRA) begin
          st_nxt.pr[0] = wd[7:0];
          st_nxt.pcnt[0] = wd[7:0]; // R19
        end else if (adr_i == OFS_PRB) begin
          st_nxt.pr[1] = wd[7:0];
          st_nxt.pcnt[1] = wd[7:0]; // R19
        end
      end
    end

    // ****************************************
    // status flags and interrupt
    // ****************************************
    // a flag raised in the clearing cycle survives
    st_nxt.ris = st_nxt.ris | set; // R08 R15
    st_nxt.irq = |(st_nxt.ris & st_nxt.imr); // R15
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ilr <= {CNT_RST, CNT_RST}; // R01
      st_r.cnt <= {CNT_RST, CNT_RST}; // R01
      st_r.pr <= {PRE_RST, PRE_RST}; // R02
      st_r.pcnt <= {PRE_RST, PRE_RST}; // R02
      st_r.mtc <= {MATCH_RST, MATCH_RST};
      st_r.mtc_hi <= MATCH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs, all straight from the state register
  // ****************************************
  assign dat_o  = st_r.dat;
  assign ack_o  = st_r.ack;
  assign trig_o = st_r.trig;
  assign irq_o  = st_r.irq;

endmodule // gpt_pair

// ===== gpt_pair_checker.sv
// concurrent checks on the ports of the timer pair
`timescale 1ns/10ps

module gpt_pair_checker
  import gpt_pkg::*;
#(
  parameter int RTC_DIV = RTC_DIV_N
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // register bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  // events
  input  wire logic [1:0]  trig_o,
  input  wire logic        irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ****************************************
  // bus handshake steps
  // ****************************************
  sequence wb_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence wb_ans;
    ack_o ##1 !ack_o;
  endsequence

  chk_ack_answer: assert property (wb_req |=> wb_ans)
    else $error("bus request not answered by a single ack");
  chk_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i && stb_i))
    else $error("ack without a request");
  chk_ack_idle: assert property (!cyc_i |=> !ack_o)
    else $error("ack while bus idle");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !ack_o && trig_o == 2'h0 && !irq_o)
    else $error("outputs active out of reset");
  chk_trig_a_pulse: assert property (trig_o[0] |=> !trig_o[0])
    else $error("trigger a longer than one cycle");
  chk_trig_b_pulse: assert property (trig_o[1] |=> !trig_o[1])
    else $error("trigger b longer than one cycle");
  // masked status read back must agree with the interrupt line of the taking cycle
  chk_irq_mis_read: assert property (ack_o && $past(adr_i == OFS_MIS && !we_i)
    |-> ((dat_o != 32'h0) == $past(irq_o)))
    else $error("masked status and interrupt disagree");
  // flags are sticky, so only a register write can drop the interrupt
  chk_irq_fall_cause: assert property ($fell(irq_o)
    |-> $past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2))
    else $error("interrupt fell without a write");
endmodule // gpt_pair_checker

bind gpt_pair gpt_pair_checker #(.RTC_DIV(RTC_DIV)) gpt_pair_checker_i (
  .clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .trig_o(trig_o), .irq_o(irq_o));

// ===== gpt_pins_model.sv
// pin-side model: slow real-time clock and edge bursts on the capture pins
`timescale 1ns/10ps

module gpt_pins_model (
  // control from the bench
  input  wire logic       rtc_on_i,
  // capture pins, bit 0 even
  output logic      [1:0] pins_o
);
  // half period of 32768 Hz, rounded to whole ns
  localparam int HALF_NS = 15259;
  initial pins_o = 2'h0;
  // slow clock runs only while asked for, so edge bursts stay clean
  always begin
    if (rtc_on_i) begin
      #(HALF_NS) pins_o[0] <= ~pins_o[0];
    end else begin
      @(rtc_on_i);
    end
  end
  // each pulse gives one rising and one falling edge, 10 clocks apart
  task pulse(input int b, input int n);
    repeat (n) begin
      pins_o[b] <= ~pins_o[b];
      #500;
      pins_o[b] <= ~pins_o[b];
      #500;
    end
  endtask
endmodule // gpt_pins_model

// ===== gpt_pair_tb.sv
// self-checking bench for the timer pair
`timescale 1ns/10ps

module gpt_pair_tb;
  import gpt_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  pin_w;
  logic [1:0]  trig_o;
  logic        irq_o;
  logic        rtc_on = 1'b0;
  logic [31:0] q;
  logic [1:0]  evs [3] = '{EV_RISE, EV_FALL, EV_BOTH};
  int          err_count = 0;
  int          compares = 0;
  int          n_cyc;

  always #25 clk_i = ~clk_i;

  // divider shortened to 4 rising pin edges per tick to keep the run short
  gpt_pair #(.RTC_DIV(4)) gpt_pair_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ccp_i(pin_w), .trig_o(trig_o), .irq_o(irq_o));
  gpt_pins_model gpt_pins_model_i (.rtc_on_i(rtc_on), .pins_o(pin_w));

  // ****************************************
  // shared tasks
  // ****************************************
  task wrap_up;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ack is sampled at the rising edge, where read data is taken and the request released
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    if (n >= 50) begin
      chk("bus ack", 32'h1, 32'h0);
      wrap_up();
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask

  // w 0/1 selects a trigger, 2 the interrupt; n_cyc counts cycles waited
  task wait_out(input int w);
    n_cyc = 0;
    do begin
      @(negedge clk_i);
      n_cyc++;
    end while ((w == 2 ? irq_o : trig_o[w]) !== 1'b1 && n_cyc < 30000);
    if (n_cyc >= 30000) begin
      chk("event wait", 32'h1, 32'h0);
      wrap_up();
    end
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'hFFFF_FFFF, "count reset");
    rd(OFS_ILRB, 32'h0000_FFFF, 32'h0000_FFFF, "load b reset");
    rd(OFS_PRA, 32'h0000_00FF, 32'h0, "prescale a reset");
    rd(OFS_PRB, 32'h0000_00FF, 32'h0, "prescale b reset");
    rd(OFS_CTL, 32'hFFFF_FFFF, 32'h0, "control reset");
    rd(8'h40, 32'hFFFF_FFFF, 32'h0, "unmapped read");
    wr(OFS_CFG, 32'h0);
    wr(OFS_MRA, {30'h0, MODE_ONE});
    wr(OFS_ILRA, 32'h1234_5678);
    rd(OFS_ILRB, 32'h0000_FFFF, 32'h0000_1234, "load b high half");
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'h1234_5678, "joined count");
    wr(OFS_ILRA, 32'h0000_0030);
    wr(OFS_CTL, 32'h0000_0021);
    wait_out(0);
    rd(OFS_RIS, 32'h1, 32'h1, "timeout raw");
    chk("masked irq", 32'h0, {31'h0, irq_o});
    rd(OFS_CTL, 32'h1, 32'h0, "one-shot stop");
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'h0000_0030, "one-shot reload");
    wr(OFS_IMR, 32'h1);
    rd(OFS_MIS, 32'h1, 32'h1, "timeout masked");
    wr(OFS_ICR, 32'h1);
    rd(OFS_RIS, 32'h1, 32'h0, "timeout cleared");
    wr(OFS_MRA, {30'h0, MODE_PER});
    wr(OFS_ILRA, 32'h0000_0020);
    wr(OFS_CTL, 32'h0000_0003);
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'h0000_0020, "stalled count");
    wr(OFS_CTL, 32'h0000_0001);
    wait_out(2);
    rd(OFS_CTL, 32'h1, 32'h1, "periodic runs on");
    wr(OFS_ILRA, 32'h0000_0500);
    wb(1'b0, OFS_CNTA, 32'h0);
    chk("live reload", 32'h1, {31'h0, q inside {[32'h0000_04F0:32'h0000_0500]}});
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'hFFFF_FFFF);
    wr(OFS_CFG, 32'h4);
    wr(OFS_MRB, {30'h0, MODE_ONE});
    wr(OFS_PRB, 32'h3);
    wr(OFS_ILRB, 32'h0000_0010);
    wr(OFS_IMR, 32'h0000_0100);
    wr(OFS_CTL, 32'h0000_2100);
    wait_out(1);
    chk("prescaled time", 32'h1, {31'h0, n_cyc inside {[63:65]}});
    rd(OFS_RIS, 32'h0000_0100, 32'h0000_0100, "half timeout");
    rd(OFS_CTL, 32'h0000_0100, 32'h0, "half one-shot stop");
    rd(OFS_CNTB, 32'h0000_FFFF, 32'h0000_0010, "half reload");
    rd(OFS_PRB, 32'h0000_00FF, 32'h3, "prescale reload");
    wr(OFS_MRA, {30'h0, MODE_PER});
    wr(OFS_ILRA, 32'h9);
    wr(OFS_CTL, 32'h0000_0021);
    wait_out(0);
    wait_out(0);
    chk("unscaled period", 32'h1, {31'h0, n_cyc inside {[9:11]}});
    wr(OFS_CTL, 32'h0);
    wr(OFS_ICR, 32'hFFFF_FFFF);
    wr(OFS_MRA, {30'h0, MODE_CAP});
    for (int i = 0; i < 3; i++) begin
      wr(OFS_CTL, 32'h0);
      wr(OFS_ILRA, 32'h5);
      wr(OFS_MATA, 32'h0);
      wr(OFS_CTL, {28'h0, evs[i], 2'b01});
      gpt_pins_model_i.pulse(0, 1);
      repeat (8) @(posedge clk_i);
      rd(OFS_CNTA, 32'h0000_FFFF, (evs[i] == EV_BOTH) ? 32'h3 : 32'h4, "edges counted");
    end
    wr(OFS_CTL, 32'h0);
    wr(OFS_ILRA, 32'h0000_000A);
    wr(OFS_MATA, 32'h6);
    wr(OFS_IMR, 32'h2);
    wr(OFS_CTL, 32'h0000_000D);
    gpt_pins_model_i.pulse(0, 3);
    repeat (8) @(posedge clk_i);
    rd(OFS_CNTA, 32'h0000_FFFF, 32'h0000_000A, "match reload");
    rd(OFS_CTL, 32'h1, 32'h0, "match disables");
    rd(OFS_RIS, 32'h2, 32'h2, "edge match raw");
    chk("edge match irq", 32'h1, {31'h0, irq_o});
    wr(OFS_ICR, 32'hFFFF_FFFF);
    wr(OFS_CFG, 32'h1);
    wr(OFS_MATA, 32'h2);
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'h1, "rtc start");
    wr(OFS_IMR, 32'h8);
    wr(OFS_CTL, 32'h0000_0013);
    rtc_on = 1'b1;
    wait_out(2);
    rd(OFS_CNTA, 32'hFFFF_FFFF, 32'h0, "rtc rollover");
    rd(OFS_MIS, 32'h8, 32'h8, "rtc masked");
    wr(OFS_ICR, 32'h8);
    rd(OFS_RIS, 32'h8, 32'h0, "rtc cleared");
    rtc_on = 1'b0;
    wrap_up();
  end
endmodule // gpt_pair_tb
